/* hw/sys_control_regs.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module sys_control_regs #(
  parameter int IRQ_LINE_COUNT = 32
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register port
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // non-maskable interrupt routing
  input wire logic [IRQ_LINE_COUNT-1:0] IRQ_LINES,
  input wire logic CLK_MON_IRQ,
  output logic NMI_REQ,
  // reset control
  input wire logic [7:0] RESET_CHECK,
  output logic SOFT_RESET_REQ,
  // wake-up timer
  output logic WAKE_IRQ,
  // oscillator trimming
  input wire logic [8:0] FACTORY_FAST_TRIM,
  input wire logic [7:0] FACTORY_SLOW_TRIM,
  output logic [8:0] FAST_TRIM,
  output logic [7:0] SLOW_TRIM,
  // clock sources
  output logic [3:0] CLK_SRC_EN,
  output logic [1:0] MAIN_CLK_SEL
);

  if (IRQ_LINE_COUNT < 1 || IRQ_LINE_COUNT > 32) begin : g_bad_count
    $error("IRQ_LINE_COUNT must lie in 1..32");
  end

  // a source may be chosen only while its oscillator is enabled
  function automatic logic source_enabled(input logic [1:0] choice, input logic [3:0] en);
    logic ok;
    ok = 1'b0;
    case (choice)
      sysctl_pkg::CHOICE_FAST_INTERNAL_RC: ok = en[sysctl_pkg::SRC_EN_FAST_BIT];
      sysctl_pkg::CHOICE_EXTERNAL_MAIN_OSC: ok = en[sysctl_pkg::SRC_EN_MAIN_BIT];
      sysctl_pkg::CHOICE_EXTERNAL_SUB_OSC: ok = en[sysctl_pkg::SRC_EN_SUB_BIT];
      default: ok = en[sysctl_pkg::SRC_EN_SLOW_BIT];
    endcase
    return ok;
  endfunction

  logic nmi_en_ff;
  logic nmi_mon_ff;
  logic [4:0] nmi_line_ff;
  logic nmi_req_ff;
  logic soft_rst_ff;
  logic [7:0] reset_val_ff;
  logic captured_ff;
  logic wake_ien_ff;
  logic wake_flag_ff;
  logic wake_pending_ff;
  logic wake_irq_ff;
  logic [23:0] wake_reload_ff;
  logic [23:0] wake_cnt_ff;
  logic [8:0] fast_trim_ff;
  logic [7:0] slow_trim_ff;
  logic [3:0] src_en_ff;
  logic [1:0] clk_choice_ff;
  logic [31:0] rdata_ff;

  wire [15:0] write_key = WDATA[31:sysctl_pkg::KEY_LSB];

  // address decode
  wire hit_nmi = (ADDR == sysctl_pkg::ADDR_NMI_SOURCE_SELECT);
  wire hit_soft_reset_code = (ADDR == sysctl_pkg::ADDR_SOFTWARE_RESET_TRIGGER);
  wire hit_valid = (ADDR == sysctl_pkg::ADDR_RESET_VALIDATION);
  wire hit_wctl = (ADDR == sysctl_pkg::ADDR_WAKEUP_TIMER_CONTROL);
  wire hit_wrld = (ADDR == sysctl_pkg::ADDR_WAKEUP_TIMER_RELOAD);
  wire hit_ftrim = (ADDR == sysctl_pkg::ADDR_FAST_RC_TRIM);
  wire hit_strim = (ADDR == sysctl_pkg::ADDR_SLOW_RC_TRIM);
  wire hit_mclk = (ADDR == sysctl_pkg::ADDR_MAIN_CLOCK_SELECT);
  wire hit_csrc = (ADDR == sysctl_pkg::ADDR_CLOCK_SOURCE_CONTROL);

  // write qualification, keyed except nmi and wake-up timer; a wrong key drops the whole write
  wire wr_nmi = WR && hit_nmi;
  wire wr_soft_reset_code = WR && hit_soft_reset_code && (write_key == sysctl_pkg::KEY_SOFT_RESET);
  wire wr_wctl = WR && hit_wctl;
  wire wr_wrld = WR && hit_wrld;
  wire wr_ftrim = WR && hit_ftrim && (write_key == sysctl_pkg::KEY_FAST_TRIM);
  wire slow_cpl_ok = (WDATA[sysctl_pkg::SLOW_CPL_MSB:sysctl_pkg::SLOW_CPL_LSB] == ~WDATA[7:0]);
  wire wr_strim = WR && hit_strim && (write_key == sysctl_pkg::KEY_SLOW_TRIM) && slow_cpl_ok;
  wire wr_mclk = WR && hit_mclk && (write_key == sysctl_pkg::KEY_MAIN_CLOCK);
  wire wr_csrc = WR && hit_csrc && (write_key == sysctl_pkg::KEY_CLOCK_SOURCE);

  // nmi source: selected line or clock monitor, gated by the enable
  logic [31:0] irq_ext;
  always_comb begin
    irq_ext = 32'h0;
    irq_ext[IRQ_LINE_COUNT-1:0] = IRQ_LINES;
  end
  wire line_hit = irq_ext[nmi_line_ff];
  wire mon_hit = nmi_mon_ff && CLK_MON_IRQ;
  wire nxt_nmi_req = nmi_en_ff && (line_hit || mon_hit);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      nmi_en_ff <= 1'b0;
      nmi_mon_ff <= 1'b0;
      nmi_line_ff <= 5'h00;
      nmi_req_ff <= 1'b0;
    end else begin
      if (wr_nmi) begin
        nmi_en_ff <= WDATA[sysctl_pkg::NMI_ENABLE_BIT];
        nmi_mon_ff <= WDATA[sysctl_pkg::NMI_CLK_MON_BIT];
        nmi_line_ff <= WDATA[sysctl_pkg::NMI_LINE_MSB:0];
      end
      nmi_req_ff <= nxt_nmi_req;
    end
  end

  // soft reset request is a one-cycle pulse; the reset controller stretches it
  wire nxt_soft_rst = wr_soft_reset_code && (WDATA[7:0] == sysctl_pkg::SOFT_RESET_CODE);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= nxt_soft_rst;
    end
  end

  // straps and factory trims cannot be loaded under async reset, so they are taken at the first edge after release
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      captured_ff <= 1'b0;
      reset_val_ff <= sysctl_pkg::RESET_VALID_CODE;
      fast_trim_ff <= 9'h000;
      slow_trim_ff <= 8'h00;
    end else begin
      captured_ff <= 1'b1;
      if (!captured_ff) begin
        reset_val_ff <= RESET_CHECK;
        fast_trim_ff <= FACTORY_FAST_TRIM;
        slow_trim_ff <= {FACTORY_SLOW_TRIM[7:4], 1'b0, FACTORY_SLOW_TRIM[2:0]};
      end else begin
        if (wr_ftrim) begin
          fast_trim_ff <= WDATA[sysctl_pkg::FAST_COARSE_MSB:0];
        end
        if (wr_strim) begin
          slow_trim_ff <= {WDATA[sysctl_pkg::SLOW_COARSE_MSB:sysctl_pkg::SLOW_COARSE_LSB], 1'b0,
                           WDATA[sysctl_pkg::SLOW_FINE_MSB:0]};
        end
      end
    end
  end

  // wake-up timer: down counter, request and reload when it reaches zero
  wire wake_tick = (wake_cnt_ff == 24'h000000);
  wire flag_clear = wr_wctl && WDATA[sysctl_pkg::WAKE_FLAG_BIT];
  wire nxt_wake_flag = wake_tick || (wake_flag_ff && !flag_clear);
  wire nxt_wake_irq = wake_ien_ff && wake_flag_ff;
  wire [23:0] nxt_wake_cnt = (wake_pending_ff || wake_tick) ? wake_reload_ff : wake_cnt_ff - 24'h000001;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wake_ien_ff <= 1'b0;
      wake_flag_ff <= 1'b0;
      wake_pending_ff <= 1'b0;
      wake_irq_ff <= 1'b0;
      wake_reload_ff <= sysctl_pkg::WAKE_RELOAD_RESET;
      wake_cnt_ff <= sysctl_pkg::WAKE_RELOAD_RESET;
    end else begin
      if (wr_wctl) begin
        wake_ien_ff <= WDATA[sysctl_pkg::WAKE_IEN_BIT];
      end
      wake_pending_ff <= wr_wctl && WDATA[sysctl_pkg::WAKE_RELOAD_BIT];
      if (wr_wrld) begin
        wake_reload_ff <= WDATA[sysctl_pkg::WAKE_VALUE_MSB:0];
      end
      wake_cnt_ff <= nxt_wake_cnt;
      wake_flag_ff <= nxt_wake_flag;
      wake_irq_ff <= nxt_wake_irq;
    end
  end

  // main clock choice refuses a source that is currently disabled
  wire choice_ok = source_enabled(WDATA[1:0], src_en_ff);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      src_en_ff <= sysctl_pkg::SRC_EN_RESET;
      clk_choice_ff <= sysctl_pkg::CHOICE_FAST_INTERNAL_RC;
    end else begin
      if (wr_csrc) begin
        src_en_ff <= WDATA[sysctl_pkg::SRC_EN_MSB:0];
      end
      if (wr_mclk && choice_ok) begin
        clk_choice_ff <= WDATA[1:0];
      end
    end
  end

  // read mux; key fields and write-only registers read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_nmi) begin
      rd_mux = {24'h0, nmi_en_ff, nmi_mon_ff, 1'b0, nmi_line_ff};
    end else if (hit_valid) begin
      rd_mux = {24'h0, reset_val_ff};
    end else if (hit_wctl) begin
      rd_mux = {24'h0, wake_ien_ff, 5'h00, wake_pending_ff, wake_flag_ff};
    end else if (hit_wrld) begin
      rd_mux = {8'h00, wake_reload_ff};
    end else if (hit_ftrim) begin
      rd_mux = {23'h0, fast_trim_ff};
    end else if (hit_strim) begin
      rd_mux = {24'h0, slow_trim_ff};
    end else if (hit_mclk) begin
      rd_mux = {30'h0, clk_choice_ff};
    end else if (hit_csrc) begin
      rd_mux = {28'h0, src_en_ff};
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= RD ? rd_mux : 32'h0;
    end
  end

  assign RDATA = rdata_ff;
  assign NMI_REQ = nmi_req_ff;
  assign SOFT_RESET_REQ = soft_rst_ff;
  assign WAKE_IRQ = wake_irq_ff;
  assign FAST_TRIM = fast_trim_ff;
  assign SLOW_TRIM = slow_trim_ff;
  assign CLK_SRC_EN = src_en_ff;
  assign MAIN_CLK_SEL = clk_choice_ff;

  a_nmi_enable_gate: assert property (@(posedge CLK) disable iff (!RST_B)
    !nmi_en_ff |=> !NMI_REQ)
    else $error("nmi raised while disabled");

  a_clk_mon_route: assert property (@(posedge CLK) disable iff (!RST_B)
    (nmi_en_ff && nmi_mon_ff && CLK_MON_IRQ) |=> NMI_REQ)
    else $error("clock monitor not routed to nmi");

  a_nmi_line_pick: assert property (@(posedge CLK) disable iff (!RST_B)
    (nmi_en_ff && !CLK_MON_IRQ) |=> (NMI_REQ == $past(irq_ext[nmi_line_ff])))
    else $error("nmi does not follow selected line");

  a_soft_reset_code_bad_key: assert property (@(posedge CLK) disable iff (!RST_B)
    (WR && hit_soft_reset_code && write_key != sysctl_pkg::KEY_SOFT_RESET) |=> !SOFT_RESET_REQ)
    else $error("soft reset taken with wrong key");

  a_soft_reset_code_code: assert property (@(posedge CLK) disable iff (!RST_B)
    wr_soft_reset_code |=> (SOFT_RESET_REQ == ($past(WDATA[7:0]) == sysctl_pkg::SOFT_RESET_CODE)))
    else $error("soft reset pulse does not match code");

  a_wake_irq_gate: assert property (@(posedge CLK) disable iff (!RST_B)
    (wake_ien_ff && wake_flag_ff) |=> WAKE_IRQ)
    else $error("wake interrupt missing");

  a_wake_reload_load: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_wctl && WDATA[sysctl_pkg::WAKE_RELOAD_BIT]) |=> ##1 (wake_cnt_ff == $past(wake_reload_ff) && !wake_pending_ff))
    else $error("counter not reloaded");

  a_wake_flag_set: assert property (@(posedge CLK) disable iff (!RST_B)
    wake_tick |=> wake_flag_ff)
    else $error("wake flag lost on request");

  a_fast_trim_key: assert property (@(posedge CLK) disable iff (!RST_B)
    (captured_ff && WR && hit_ftrim && write_key != sysctl_pkg::KEY_FAST_TRIM) |=> $stable(FAST_TRIM))
    else $error("fast trim changed by unkeyed write");

  a_slow_trim_cpl: assert property (@(posedge CLK) disable iff (!RST_B)
    (captured_ff && WR && hit_strim && !slow_cpl_ok) |=> $stable(SLOW_TRIM))
    else $error("slow trim changed with bad complement");

  a_clock_refuse: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_mclk && !source_enabled(WDATA[1:0], src_en_ff)) |=> $stable(MAIN_CLK_SEL))
    else $error("disabled source was selected");

  a_clk_src_key: assert property (@(posedge CLK) disable iff (!RST_B)
    (WR && hit_csrc && write_key != sysctl_pkg::KEY_CLOCK_SOURCE) |=> $stable(CLK_SRC_EN))
    else $error("clock sources changed by unkeyed write");

  a_nmi_cfg_write: assert property (@(posedge CLK) disable iff (!RST_B)
    wr_nmi |=> (nmi_line_ff == $past(WDATA[sysctl_pkg::NMI_LINE_MSB:0])
      && nmi_en_ff == $past(WDATA[sysctl_pkg::NMI_ENABLE_BIT])))
    else $error("nmi source fields not stored");

  a_soft_reset_code_no_cause: assert property (@(posedge CLK) disable iff (!RST_B)
    !wr_soft_reset_code |=> !SOFT_RESET_REQ)
    else $error("soft reset pulse without keyed write");

  a_reset_valid_ro: assert property (@(posedge CLK) disable iff (!RST_B)
    captured_ff |=> $stable(reset_val_ff))
    else $error("validation byte changed after capture");

  a_wake_irq_off: assert property (@(posedge CLK) disable iff (!RST_B)
    !wake_ien_ff |=> !WAKE_IRQ)
    else $error("wake interrupt raised while disabled");

  a_wake_count_down: assert property (@(posedge CLK) disable iff (!RST_B)
    (!wake_pending_ff && !wake_tick) |=> (wake_cnt_ff == $past(wake_cnt_ff) - 24'h000001))
    else $error("wake counter did not step down");

  a_wake_flag_clear: assert property (@(posedge CLK) disable iff (!RST_B)
    (flag_clear && !wake_tick) |=> !wake_flag_ff)
    else $error("wake flag not cleared by write one");

  a_wake_reload_write: assert property (@(posedge CLK) disable iff (!RST_B)
    wr_wrld |=> (wake_reload_ff == $past(WDATA[sysctl_pkg::WAKE_VALUE_MSB:0])))
    else $error("reload value not stored");

  a_fast_trim_factory: assert property (@(posedge CLK) disable iff (!RST_B)
    !captured_ff |=> (FAST_TRIM == $past(FACTORY_FAST_TRIM)))
    else $error("fast trim not taken from factory value");

  a_fast_trim_load: assert property (@(posedge CLK) disable iff (!RST_B)
    (captured_ff && wr_ftrim) |=> (FAST_TRIM == $past(WDATA[sysctl_pkg::FAST_COARSE_MSB:0])))
    else $error("keyed fast trim write not stored");

  a_slow_trim_factory: assert property (@(posedge CLK) disable iff (!RST_B)
    !captured_ff |=> (SLOW_TRIM == {$past(FACTORY_SLOW_TRIM[7:4]), 1'b0, $past(FACTORY_SLOW_TRIM[2:0])}))
    else $error("slow trim not taken from factory value");

  a_slow_trim_load: assert property (@(posedge CLK) disable iff (!RST_B)
    (captured_ff && wr_strim) |=>
      (SLOW_TRIM[7:4] == $past(WDATA[sysctl_pkg::SLOW_COARSE_MSB:sysctl_pkg::SLOW_COARSE_LSB])
      && SLOW_TRIM[2:0] == $past(WDATA[sysctl_pkg::SLOW_FINE_MSB:0]) && !SLOW_TRIM[3]))
    else $error("keyed slow trim write not stored");

  a_slow_trim_key: assert property (@(posedge CLK) disable iff (!RST_B)
    (captured_ff && WR && hit_strim && write_key != sysctl_pkg::KEY_SLOW_TRIM) |=> $stable(SLOW_TRIM))
    else $error("slow trim changed by unkeyed write");

  a_main_clock_key: assert property (@(posedge CLK) disable iff (!RST_B)
    (WR && hit_mclk && write_key != sysctl_pkg::KEY_MAIN_CLOCK) |=> $stable(MAIN_CLK_SEL))
    else $error("main clock changed by unkeyed write");

  a_main_clock_take: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_mclk && source_enabled(WDATA[1:0], src_en_ff)) |=> (MAIN_CLK_SEL == $past(WDATA[1:0])))
    else $error("enabled source not selected");

  a_clk_src_take: assert property (@(posedge CLK) disable iff (!RST_B)
    wr_csrc |=> (CLK_SRC_EN == $past(WDATA[sysctl_pkg::SRC_EN_MSB:0])))
    else $error("keyed clock source write not stored");

  a_rdata_idle: assert property (@(posedge CLK) disable iff (!RST_B)
    !RD |=> (RDATA == 32'h0))
    else $error("read data shown without a read");

  a_key_reads_zero: assert property (@(posedge CLK) disable iff (!RST_B)
    (RD && (hit_soft_reset_code || hit_ftrim || hit_strim || hit_mclk || hit_csrc)) |=>
      (RDATA[31:sysctl_pkg::KEY_LSB] == 16'h0000))
    else $error("key field read back nonzero");

endmodule // sys_control_regs

/* hw/sysctl_pkg.sv */
package sysctl_pkg;

  // byte addresses on the register port
  localparam logic [31:0] ADDR_MAIN_CLOCK_SELECT = 32'h40001800;
  localparam logic [31:0] ADDR_CLOCK_SOURCE_CONTROL = 32'h40001804;
  localparam logic [31:0] ADDR_NMI_SOURCE_SELECT = 32'h4000f020;
  localparam logic [31:0] ADDR_SOFTWARE_RESET_TRIGGER = 32'h4000f024;
  localparam logic [31:0] ADDR_RESET_VALIDATION = 32'h4000f028;
  localparam logic [31:0] ADDR_WAKEUP_TIMER_CONTROL = 32'h4000f02c;
  localparam logic [31:0] ADDR_WAKEUP_TIMER_RELOAD = 32'h4000f030;
  localparam logic [31:0] ADDR_FAST_RC_TRIM = 32'h4000f0a8;
  localparam logic [31:0] ADDR_SLOW_RC_TRIM = 32'h4000f0ac;

  // write keys, carried in the upper halfword
  localparam int KEY_LSB = 16;
  localparam logic [15:0] KEY_SOFT_RESET = 16'h9eb3;
  localparam logic [15:0] KEY_FAST_TRIM = 16'ha6b5;
  localparam logic [15:0] KEY_SLOW_TRIM = 16'h4c3d;
  localparam logic [15:0] KEY_MAIN_CLOCK = 16'h570a;
  localparam logic [15:0] KEY_CLOCK_SOURCE = 16'ha507;

  localparam logic [7:0] SOFT_RESET_CODE = 8'h2d;
  localparam logic [7:0] RESET_VALID_CODE = 8'h55;

  // nmi source select fields
  localparam int NMI_ENABLE_BIT = 7;
  localparam int NMI_CLK_MON_BIT = 6;
  localparam int NMI_LINE_MSB = 4;

  // wake-up timer control fields
  localparam int WAKE_IEN_BIT = 7;
  localparam int WAKE_RELOAD_BIT = 1;
  localparam int WAKE_FLAG_BIT = 0;
  localparam int WAKE_VALUE_MSB = 23;
  localparam logic [23:0] WAKE_RELOAD_RESET = 24'h001f40;

  // trim fields
  localparam int FAST_COARSE_MSB = 8;
  localparam int FAST_COARSE_LSB = 6;
  localparam int FAST_FINE_MSB = 5;
  localparam int SLOW_CPL_MSB = 15;
  localparam int SLOW_CPL_LSB = 8;
  localparam int SLOW_COARSE_MSB = 7;
  localparam int SLOW_COARSE_LSB = 4;
  localparam int SLOW_FINE_MSB = 2;

  // clock source enables and main clock choice codes
  localparam int SRC_EN_MSB = 3;
  localparam logic [3:0] SRC_EN_RESET = 4'hc;
  localparam int SRC_EN_SUB_BIT = 0;
  localparam int SRC_EN_MAIN_BIT = 1;
  localparam int SRC_EN_FAST_BIT = 2;
  localparam int SRC_EN_SLOW_BIT = 3;
  localparam logic [1:0] CHOICE_FAST_INTERNAL_RC = 2'h0;
  localparam logic [1:0] CHOICE_EXTERNAL_MAIN_OSC = 2'h1;
  localparam logic [1:0] CHOICE_EXTERNAL_SUB_OSC = 2'h2;
  localparam logic [1:0] CHOICE_SLOW_INTERNAL_RC = 2'h3;

endpackage

/* tb/sys_control_regs_tb.sv */
`timescale 1ns/1ps
module sys_control_regs_tb;
  logic clk, rst_b, wr, rd, clk_mon_irq;
  logic [31:0] addr, wdata, rdata, irq_lines;
  logic [7:0] reset_check, factory_slow_trim, slow_trim;
  logic [8:0] factory_fast_trim, fast_trim;
  logic nmi_req, soft_reset_req, wake_irq;
  logic [3:0] clk_src_en;
  logic [1:0] main_clk_sel;
  int miscompares, check_count, n;

  sys_control_regs u_dut (
    .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .IRQ_LINES(irq_lines), .CLK_MON_IRQ(clk_mon_irq), .NMI_REQ(nmi_req), .RESET_CHECK(reset_check),
    .SOFT_RESET_REQ(soft_reset_req), .WAKE_IRQ(wake_irq), .FACTORY_FAST_TRIM(factory_fast_trim),
    .FACTORY_SLOW_TRIM(factory_slow_trim), .FAST_TRIM(fast_trim), .SLOW_TRIM(slow_trim),
    .CLK_SRC_EN(clk_src_en), .MAIN_CLK_SEL(main_clk_sel)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every access ends 1 ns past the taking edge, inside the answer cycle
  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // NMI_REQ follows its sources one cycle late, so look two edges after the write
  task automatic nmi_case(input logic [31:0] cfg, input logic [31:0] lines, input logic mon, input logic exp);
    @(posedge clk);
    irq_lines <= lines;
    clk_mon_irq <= mon;
    reg_wr(32'h4000f020, cfg);
    repeat (2) @(posedge clk);
    #1;
    check("nmi_req", {31'h0, nmi_req}, {31'h0, exp});
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    irq_lines = 32'h0;
    clk_mon_irq = 1'b0;
    reset_check = 8'h55;
    factory_fast_trim = 9'h1a5;
    factory_slow_trim = 8'h5b;
    do_reset();
    rd_chk("clk_src", 32'h40001804, 32'h0000000c);
    rd_chk("main_sel", 32'h40001800, 32'h0);
    rd_chk("reload", 32'h4000f030, 32'h001f40);
    rd_chk("valid", 32'h4000f028, 32'h55);
    // read data stands for one cycle only, then falls back to zero
    @(posedge clk);
    #1;
    check("rdata_idle", rdata, 32'h0);
    rd_chk("fast_rd", 32'h4000f0a8, 32'h1a5);
    check("fast_trim", {23'h0, fast_trim}, 32'h1a5);
    rd_chk("slow_rd", 32'h4000f0ac, 32'h53);
    check("slow_trim", {24'h0, slow_trim}, 32'h53);
    rd_chk("unmapped", 32'h4000f040, 32'h0);
    reg_wr(32'h4000f028, 32'h000000aa);
    rd_chk("valid_ro", 32'h4000f028, 32'h55);
    reg_wr(32'h40001800, 32'h12340003);
    check("sel_badkey", {30'h0, main_clk_sel}, 32'h0);
    reg_wr(32'h40001800, 32'h570a0001);
    check("sel_disabled", {30'h0, main_clk_sel}, 32'h0);
    reg_wr(32'h40001804, 32'ha506000f);
    check("src_badkey", {28'h0, clk_src_en}, 32'hc);
    reg_wr(32'h40001804, 32'ha507000f);
    check("src_all", {28'h0, clk_src_en}, 32'hf);
    // this block has no bus divider, so slow sources need no divider set-up
    for (n = 0; n < 4; n++) begin
      reg_wr(32'h40001800, {16'h570a, 14'h0, n[1:0]});
      check("sel_code", {30'h0, main_clk_sel}, {30'h0, n[1:0]});
    end
    rd_chk("sel_rd", 32'h40001800, 32'h3);
    reg_wr(32'h40001804, 32'ha507000e);
    reg_wr(32'h40001800, 32'h570a0002);
    check("sel_sub_off", {30'h0, main_clk_sel}, 32'h3);
    reg_wr(32'h4000f024, 32'h9eb2002d);
    check("swr_badkey", {31'h0, soft_reset_req}, 32'h0);
    reg_wr(32'h4000f024, 32'h9eb3002c);
    check("swr_badcode", {31'h0, soft_reset_req}, 32'h0);
    reg_wr(32'h4000f024, 32'h9eb3002d);
    check("swr_pulse", {31'h0, soft_reset_req}, 32'h1);
    @(posedge clk);
    #1;
    check("swr_end", {31'h0, soft_reset_req}, 32'h0);
    nmi_case(32'h85, 32'h20, 1'b0, 1'b1);
    nmi_case(32'h05, 32'h20, 1'b0, 1'b0);
    nmi_case(32'h86, 32'h20, 1'b0, 1'b0);
    nmi_case(32'h9f, 32'h80000000, 1'b0, 1'b1);
    nmi_case(32'hc0, 32'h0, 1'b1, 1'b1);
    nmi_case(32'h80, 32'h0, 1'b1, 1'b0);
    rd_chk("nmi_rd", 32'h4000f020, 32'h80);
    reg_wr(32'h4000f0a8, 32'ha6b400f3);
    check("fast_badkey", {23'h0, fast_trim}, 32'h1a5);
    reg_wr(32'h4000f0a8, 32'ha6b500f3);
    check("fast_new", {23'h0, fast_trim}, 32'hf3);
    rd_chk("fast_new_rd", 32'h4000f0a8, 32'hf3);
    reg_wr(32'h4000f0ac, 32'h4c3d006a);
    check("slow_badcpl", {24'h0, slow_trim}, 32'h53);
    reg_wr(32'h4000f0ac, 32'h4c3c956a);
    check("slow_badkey", {24'h0, slow_trim}, 32'h53);
    reg_wr(32'h4000f0ac, 32'h4c3d956a);
    check("slow_new", {24'h0, slow_trim}, 32'h62);
    // short period so the flag comes up quickly
    reg_wr(32'h4000f030, 32'hff000003);
    rd_chk("reload_rd", 32'h4000f030, 32'h000003);
    // single clock, so the peripheral clock never lags the bus clock
    reg_wr(32'h4000f02c, 32'h00000082);
    n = 0;
    while (wake_irq !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("wake_irq", {31'h0, wake_irq}, 32'h1);
    reg_wr(32'h4000f030, 32'h00000fff);
    reg_wr(32'h4000f02c, 32'h00000002);
    rd_chk("wake_flag", 32'h4000f02c, 32'h1);
    repeat (2) @(posedge clk);
    n = 0;
    repeat (12) begin
      @(posedge clk);
      if (wake_irq !== 1'b0) n++;
    end
    check("wake_masked", n, 32'h0);
    reg_wr(32'h4000f02c, 32'h00000001);
    rd_chk("wake_clr", 32'h4000f02c, 32'h0);
    // weak reset: validation byte shows what the reset circuitry reported
    reset_check <= 8'h3c;
    do_reset();
    rd_chk("valid_weak", 32'h4000f028, 32'h3c);
    check("fast_again", {23'h0, fast_trim}, 32'h1a5);
    check("sel_again", {30'h0, main_clk_sel}, 32'h0);
    rd_chk("reload_again", 32'h4000f030, 32'h001f40);
    print_verdict();
  end
endmodule // sys_control_regs_tb
